// [cpm_pin_cell.sv]
// package of shared constants and one configurable pin cell
// assumes a single 100 MHz clock and an asynchronous active-low reset
package cpm_pkg;
  // =====================================================================
  // pin function options
  typedef enum logic [4:0] {
    OPT_TRISTATE = 5'h00,
    OPT_DRIVE1 = 5'h01,
    OPT_DRIVE0 = 5'h02,
    OPT_LINE_DRV = 5'h03,
    OPT_POWER_EN = 5'h04,
    OPT_SEND_LED = 5'h05,
    OPT_RECV_LED = 5'h06,
    OPT_TRAFFIC_LED = 5'h07,
    OPT_SLEEP = 5'h08,
    OPT_CLK24 = 5'h09,
    OPT_CLK12 = 5'h0a,
    OPT_CLK6 = 5'h0b,
    OPT_GPIO = 5'h0c,
    OPT_CHARGER = 5'h0d,
    OPT_CHARGER_N = 5'h0e,
    OPT_WR_STROBE = 5'h0f,
    OPT_RD_STROBE = 5'h10,
    OPT_BUS_SENSE = 5'h11,
    OPT_TIMESTAMP = 5'h12,
    OPT_KEEP_AWAKE = 5'h13
  } cpm_opt_t;
  localparam int OPT_COUNT = 20;
  localparam int SEL_W = 5;
  localparam int PIN_COUNT = 4;
  localparam int SEL_ALL_W = SEL_W * PIN_COUNT;
  // =====================================================================
  // power-up selection: line driver, receive led, send led, sleep
  localparam logic [SEL_ALL_W-1:0] SEL_DEFAULT = {
    OPT_SLEEP, OPT_SEND_LED, OPT_RECV_LED, OPT_LINE_DRV};
  // =====================================================================
  // register map (byte addresses) and fields
  localparam logic [7:0] ADDR_SEL = 8'h00;
  localparam logic [7:0] ADDR_CTRL = 8'h04;
  localparam logic [7:0] ADDR_GPIO = 8'h08;
  localparam logic [7:0] ADDR_STATUS = 8'h0c;
  localparam int CTRL_PULLDN_BIT = 0;
  localparam int CTRL_RELOAD_BIT = 1;
  localparam int GPIO_OE_LSB = 4;
  localparam int ST_BUSPWR_BIT = 4;
  localparam int ST_AWAKE_BIT = 5;
  localparam int ST_SUSP_BIT = 6;
  localparam int ST_STAMP_BIT = 7;
  localparam int ST_LOADED_BIT = 8;
  // =====================================================================
  // timing
  localparam longint CLK_HZ = 100_000_000;
  localparam longint FAST_TOGGLE_HZ = 48_000_000;
  localparam int NCO_W = 16;
  localparam logic [NCO_W-1:0] NCO_INC =
    NCO_W'((FAST_TOGGLE_HZ * (64'h1 << NCO_W)) / CLK_HZ);
  localparam longint LED_STRETCH_US = 1000;
  localparam int LED_STRETCH_CYC =
    int'((LED_STRETCH_US * CLK_HZ) / 1_000_000);
  localparam int LED_CNT_W = 20;
endpackage

`timescale 1ns/10ps
module cpm_pin_cell
  import cpm_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // selection and sources
  input wire logic [SEL_W-1:0] sel,
  input wire logic [OPT_COUNT-1:0] srcLevel,
  input wire logic gpioOut,
  input wire logic gpioOe,
  input wire logic suspPullDn,
  // pad controls
  output logic padOut,
  output logic padOe,
  output logic padPullUp,
  output logic padPullDn
);
  logic outD;
  logic oeD;
  logic inputMode;

  always_comb begin
    outD = 1'b0;
    oeD = 1'b1;
    inputMode = 1'b0;
    case (cpm_opt_t'(sel))
      OPT_TRISTATE: begin
        oeD = 1'b0;
      end
      OPT_GPIO: begin
        outD = gpioOut;
        oeD = gpioOe;
        inputMode = ~gpioOe;
      end
      OPT_BUS_SENSE, OPT_KEEP_AWAKE: begin
        oeD = 1'b0;
        inputMode = 1'b1;
      end
      default: begin
        // unused codes fall back to a low drive, never an unknown
        outD = (sel < SEL_W'(OPT_COUNT)) ? srcLevel[sel] : 1'b0;
      end
    endcase
  end

  // =====================================================================
  // registered pad drive
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      padOut <= 1'b0;
      padOe <= 1'b0;
      padPullUp <= 1'b1;
      padPullDn <= 1'b0;
    end else begin
      padOut <= outD;
      padOe <= oeD;
      padPullUp <= inputMode & ~suspPullDn;
      padPullDn <= inputMode & suspPullDn;
    end
  end
endmodule

// [cpm_pin_mux.sv]
// four configurable pins, each muxing one function from a shared set
// assumes usb, uart and bit-bang status come from logic on clk;
// pad inputs are asynchronous and are synchronised here
`timescale 1ns/10ps
module cpm_pin_mux
  import cpm_pkg::*;
#(
  parameter int LedStretchCyc = LED_STRETCH_CYC
)
(
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // nonvolatile configuration
  input wire logic [SEL_ALL_W-1:0] nvmSel,
  input wire logic nvmValid,
  // device status
  input wire logic uartSending,
  input wire logic usbConfigured,
  input wire logic usbSuspend,
  input wire logic usbSendEvent,
  input wire logic usbRecvEvent,
  input wire logic usbSofEvent,
  input wire logic chargerDetected,
  input wire logic parallelWriteStrobeN,
  input wire logic parallelReadStrobeN,
  // results for the device
  output logic busPowerSense,
  output logic keepAwake,
  // pads
  input wire logic [PIN_COUNT-1:0] padIn,
  output logic [PIN_COUNT-1:0] padOut,
  output logic [PIN_COUNT-1:0] padOe,
  output logic [PIN_COUNT-1:0] padPullUp,
  output logic [PIN_COUNT-1:0] padPullDn
);
  logic [SEL_ALL_W-1:0] sel_q;
  logic loadPending_q;
  logic suspPullDn_q;
  logic [PIN_COUNT-1:0] gpioOut_q;
  logic [PIN_COUNT-1:0] gpioOe_q;
  logic [PIN_COUNT-1:0] padSync1_q;
  logic [PIN_COUNT-1:0] padSync2_q;
  logic stamp_q;
  logic [NCO_W-1:0] nco_q;
  logic clk24_q;
  logic clk12_q;
  logic clk6_q;
  logic [2:0] ledFire;
  logic [2:0] ledOn;
  logic [OPT_COUNT-1:0] srcLevel;
  logic [PIN_COUNT-1:0] senseHit;
  logic [PIN_COUNT-1:0] awakeHit;
  logic [NCO_W:0] ncoSum;
  logic setup;
  logic access;
  logic [31:0] rdD;
  logic errD;

  // =====================================================================
  // selection load; held between reloads
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sel_q <= SEL_DEFAULT;
      loadPending_q <= 1'b1;
    end else if (access && pwrite && paddr == ADDR_CTRL &&
                 pwdata[CTRL_RELOAD_BIT]) begin
      // re-arm wins over a load in the same cycle
      loadPending_q <= 1'b1;
    end else if (loadPending_q && nvmValid) begin
      sel_q <= nvmSel;
      loadPending_q <= 1'b0;
    end
  end

  // =====================================================================
  // pad input synchroniser
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      padSync1_q <= '1;
      padSync2_q <= '1;
    end else begin
      padSync1_q <= padIn;
      padSync2_q <= padSync1_q;
    end
  end

  // =====================================================================
  // timestamp toggle
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      stamp_q <= 1'b0;
    end else if (usbSofEvent) begin
      stamp_q <= ~stamp_q;
    end
  end

  // =====================================================================
  // clock outputs from a phase accumulator; edges jitter by one
  // system cycle since 48 MHz does not divide 100 MHz
  assign ncoSum = {1'b0, nco_q} + {1'b0, NCO_INC};

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      nco_q <= '0;
      clk24_q <= 1'b0;
      clk12_q <= 1'b0;
      clk6_q <= 1'b0;
    end else if (usbSuspend) begin
      nco_q <= '0;
      clk24_q <= 1'b0;
      clk12_q <= 1'b0;
      clk6_q <= 1'b0;
    end else begin
      nco_q <= ncoSum[NCO_W-1:0];
      if (ncoSum[NCO_W]) begin
        clk24_q <= ~clk24_q;
        if (clk24_q) begin
          clk12_q <= ~clk12_q;
          if (clk12_q) begin
            clk6_q <= ~clk6_q;
          end
        end
      end
    end
  end

  // =====================================================================
  // led stretchers: send, receive, traffic
  assign ledFire[0] = usbSendEvent;
  assign ledFire[1] = usbRecvEvent;
  assign ledFire[2] = usbSendEvent | usbRecvEvent;

  for (genvar i = 0; i < 3; i++) begin : gLed
    logic [LED_CNT_W-1:0] cnt_q;
    always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
        cnt_q <= '0;
      end else if (ledFire[i]) begin
        cnt_q <= LED_CNT_W'(LedStretchCyc);
      end else if (cnt_q != '0) begin
        cnt_q <= cnt_q - LED_CNT_W'(1);
      end
    end
    assign ledOn[i] = (cnt_q != '0);
  end

  // =====================================================================
  // option source levels
  always_comb begin
    srcLevel = '0;
    srcLevel[OPT_DRIVE1] = 1'b1;
    srcLevel[OPT_DRIVE0] = 1'b0;
    srcLevel[OPT_LINE_DRV] = uartSending;
    srcLevel[OPT_POWER_EN] = usbSuspend | ~usbConfigured;
    srcLevel[OPT_SEND_LED] = ~ledOn[0];
    srcLevel[OPT_RECV_LED] = ~ledOn[1];
    srcLevel[OPT_TRAFFIC_LED] = ~ledOn[2];
    srcLevel[OPT_SLEEP] = ~usbSuspend;
    srcLevel[OPT_CLK24] = clk24_q;
    srcLevel[OPT_CLK12] = clk12_q;
    srcLevel[OPT_CLK6] = clk6_q;
    srcLevel[OPT_CHARGER] = chargerDetected;
    srcLevel[OPT_CHARGER_N] = ~chargerDetected;
    srcLevel[OPT_WR_STROBE] = parallelWriteStrobeN;
    srcLevel[OPT_RD_STROBE] = parallelReadStrobeN;
    srcLevel[OPT_TIMESTAMP] = stamp_q;
  end

  // =====================================================================
  // pin cells
  for (genvar p = 0; p < PIN_COUNT; p++) begin : gPin
    logic [SEL_W-1:0] pinSel;
    assign pinSel = sel_q[p*SEL_W +: SEL_W];
    assign senseHit[p] = (pinSel == OPT_BUS_SENSE) & padSync2_q[p];
    assign awakeHit[p] = (pinSel == OPT_KEEP_AWAKE) & ~padSync2_q[p];
    cpm_pin_cell uCell (
      .clk(clk),
      .rst_n(rst_n),
      .sel(pinSel),
      .srcLevel(srcLevel),
      .gpioOut(gpioOut_q[p]),
      .gpioOe(gpioOe_q[p]),
      .suspPullDn(suspPullDn_q & usbSuspend),
      .padOut(padOut[p]),
      .padOe(padOe[p]),
      .padPullUp(padPullUp[p]),
      .padPullDn(padPullDn[p])
    );
  end

  // =====================================================================
  // sensed inputs
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      busPowerSense <= 1'b0;
      keepAwake <= 1'b0;
    end else begin
      busPowerSense <= |senseHit;
      keepAwake <= |awakeHit;
    end
  end

  // =====================================================================
  // apb slave: no wait state; read data is registered in the setup phase so it comes from a flop
  assign setup = psel & ~penable & ~pready;
  // writes land only at the edge that completes the access
  assign access = psel & penable & pready;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      suspPullDn_q <= 1'b0;
      gpioOut_q <= '0;
      gpioOe_q <= '0;
    end else if (access && pwrite) begin
      if (paddr == ADDR_CTRL) begin
        suspPullDn_q <= pwdata[CTRL_PULLDN_BIT];
      end else if (paddr == ADDR_GPIO) begin
        gpioOut_q <= pwdata[PIN_COUNT-1:0];
        gpioOe_q <= pwdata[GPIO_OE_LSB +: PIN_COUNT];
      end
    end
  end

  always_comb begin
    rdD = '0;
    errD = 1'b0;
    if (paddr == ADDR_SEL) begin
      rdD[SEL_ALL_W-1:0] = sel_q;
      errD = pwrite;
    end else if (paddr == ADDR_CTRL) begin
      rdD[CTRL_PULLDN_BIT] = suspPullDn_q;
    end else if (paddr == ADDR_GPIO) begin
      rdD[PIN_COUNT-1:0] = gpioOut_q;
      rdD[GPIO_OE_LSB +: PIN_COUNT] = gpioOe_q;
    end else if (paddr == ADDR_STATUS) begin
      rdD[PIN_COUNT-1:0] = padSync2_q;
      rdD[ST_BUSPWR_BIT] = busPowerSense;
      rdD[ST_AWAKE_BIT] = keepAwake;
      rdD[ST_SUSP_BIT] = usbSuspend;
      rdD[ST_STAMP_BIT] = stamp_q;
      rdD[ST_LOADED_BIT] = ~loadPending_q;
      errD = pwrite;
    end else begin
      errD = 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= '0;
    end else if (setup) begin
      pready <= 1'b1;
      pslverr <= errD;
      prdata <= pwrite ? 32'h0000_0000 : rdD;
    end else begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= '0;
    end
  end
endmodule

// [cpm_pin_mux_props.sv]
// checker on the pin mux ports
// assumes bind to cpm_pin_mux; shadows the loaded selection
`timescale 1ns/10ps
module cpm_pin_mux_props
  import cpm_pkg::*;
(
  // clock, reset, bus
  input wire logic clk,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic pready,
  // sources
  input wire logic [SEL_ALL_W-1:0] nvmSel,
  input wire logic nvmValid,
  input wire logic uartSending,
  input wire logic usbConfigured,
  input wire logic usbSuspend,
  input wire logic usbSendEvent,
  input wire logic usbRecvEvent,
  input wire logic usbSofEvent,
  input wire logic busPowerSense,
  // pads
  input wire logic [PIN_COUNT-1:0] padIn,
  input wire logic [PIN_COUNT-1:0] padOut,
  input wire logic [PIN_COUNT-1:0] padOe
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  // =====
  // shadow selection; live_q masks the reset-exit pipeline cycle
  logic live_q, pend_q;
  logic [SEL_ALL_W-1:0] sel_q;
  logic [SEL_W-1:0] s0, s1, s2, s3;
  assign {s3, s2, s1, s0} = sel_q;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      live_q <= 1'b0;
      pend_q <= 1'b1;
      sel_q <= SEL_DEFAULT;
    end else begin
      live_q <= 1'b1;
      if (psel && penable && pready && pwrite && paddr == ADDR_CTRL &&
          pwdata[CTRL_RELOAD_BIT]) begin
        pend_q <= 1'b1;
      end else if (pend_q && nvmValid) begin
        pend_q <= 1'b0;
        sel_q <= nvmSel;
      end
    end
  end
  // =====
  // properties
  property p_tri; $past(s0) == OPT_TRISTATE |-> !padOe[0]; endproperty
  a_tri: assert property (p_tri) else $error("tristate driven");
  property p_cst;
    $past(s0) == OPT_DRIVE1 || $past(s0) == OPT_DRIVE0
      |-> padOe[0] && padOut[0] == ($past(s0) == OPT_DRIVE1);
  endproperty
  a_cst: assert property (p_cst) else $error("constant wrong");
  property p_line;
    live_q && $past(s0) == OPT_LINE_DRV
      |-> padOe[0] && padOut[0] == $past(uartSending);
  endproperty
  a_line: assert property (p_line) else $error("line drv");
  property p_pwr;
    live_q && $past(s2) == OPT_POWER_EN
      |-> padOut[2] == $past(usbSuspend || !usbConfigured);
  endproperty
  a_pwr: assert property (p_pwr) else $error("power enable");
  property p_slp;
    live_q && $past(s3) == OPT_SLEEP |-> padOut[3] == !$past(usbSuspend);
  endproperty
  a_slp: assert property (p_slp) else $error("sleep level");
  property p_snd; s2 == OPT_SEND_LED && usbSendEvent |-> ##2 !padOut[2];
  endproperty
  a_snd: assert property (p_snd) else $error("send led");
  property p_rcv; s1 == OPT_RECV_LED && usbRecvEvent |-> ##2 !padOut[1];
  endproperty
  a_rcv: assert property (p_rcv) else $error("recv led");
  property p_ts;
    s3 == OPT_TIMESTAMP && $past(s3) == OPT_TIMESTAMP && usbSofEvent
      |-> ##2 padOut[3] != $past(padOut[3]);
  endproperty
  a_ts: assert property (p_ts) else $error("stamp toggle");
  property p_sns; (s0 == OPT_BUS_SENSE && padIn[0])[*4] |-> busPowerSense;
  endproperty
  a_sns: assert property (p_sns) else $error("bus sense");
  c_ts: cover property (s3 == OPT_TIMESTAMP && usbSofEvent);
  c_sns: cover property (s0 == OPT_BUS_SENSE && busPowerSense);
  c_snd: cover property (s2 == OPT_SEND_LED && usbSendEvent);
endmodule

bind cpm_pin_mux cpm_pin_mux_props u_chk (.clk, .rst_n, .psel, .penable,
  .pwrite, .paddr, .pwdata, .pready, .nvmSel, .nvmValid, .uartSending,
  .usbConfigured, .usbSuspend, .usbSendEvent, .usbRecvEvent,
  .usbSofEvent, .busPowerSense, .padIn, .padOut, .padOe);

// [cpm_board_model.sv]
// board beside the pads: outside drivers, pulls, floating lines
// assumes outside parties drive only pins the mux has released
`timescale 1ns/10ps
module cpm_board_model
  import cpm_pkg::*;
(
  // clock
  input wire logic clk,
  // pad side of the mux
  input wire logic [PIN_COUNT-1:0] padOut,
  input wire logic [PIN_COUNT-1:0] padOe,
  input wire logic [PIN_COUNT-1:0] padPullUp,
  input wire logic [PIN_COUNT-1:0] padPullDn,
  // outside parties: sense source, keep-awake switch
  input wire logic [PIN_COUNT-1:0] extDrv,
  input wire logic [PIN_COUNT-1:0] extLvl,
  output logic [PIN_COUNT-1:0] padIn
);
  logic [PIN_COUNT-1:0] last_q = 4'h0;
  always @(posedge clk) last_q <= padIn;
  always_comb begin
    for (int i = 0; i < PIN_COUNT; i++) begin
      if (padOe[i]) padIn[i] = padOut[i];
      else if (extDrv[i]) padIn[i] = extLvl[i];
      else if (padPullUp[i] || padPullDn[i]) padIn[i] = padPullUp[i];
      // unpulled line must not keep a stale level
      else padIn[i] = ~last_q[i];
    end
  end
endmodule

// [cpm_pin_mux_bench.sv]
// self-checking bench for the four-pin function mux
// assumes the board model on the pads and the bound checker
`timescale 1ns/10ps
module cpm_pin_mux_bench
  import cpm_pkg::*;
;
  localparam int LS = 8;
  logic clk = 1'b0, rst_n = 1'b0, psel = 1'b0, penable = 1'b0;
  logic pwrite = 1'b0, pready, pslverr, err, nvmValid = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic [SEL_ALL_W-1:0] nvmSel = 20'h0;
  logic uartSending = 1'b1, usbConfigured = 1'b1, usbSuspend = 1'b0;
  logic chargerDetected = 1'b0, parallelWriteStrobeN = 1'b1;
  logic parallelReadStrobeN = 1'b1, busPowerSense, keepAwake;
  logic [2:0] ev = 3'h0;
  logic [3:0] padIn, padOut, padOe, padPullUp, padPullDn;
  logic [3:0] extDrv = 4'h0, extLvl = 4'h1;
  int failures = 0, comparisons = 0, n, e;
  // =====
  // design and board
  initial forever #5 clk = ~clk;
  cpm_pin_mux #(.LedStretchCyc(LS)) dut (.clk, .rst_n, .psel, .penable,
    .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .nvmSel,
    .nvmValid, .uartSending, .usbConfigured, .usbSuspend,
    .usbSendEvent(ev[0]), .usbRecvEvent(ev[1]), .usbSofEvent(ev[2]),
    .chargerDetected, .parallelWriteStrobeN, .parallelReadStrobeN,
    .busPowerSense, .keepAwake, .padIn, .padOut, .padOe, .padPullUp,
    .padPullDn);
  cpm_board_model board (.clk, .padOut, .padOe, .padPullUp, .padPullDn,
    .extDrv, .extLvl, .padIn);
  // =====
  // tasks; pads are read just after an edge, before its updates land
  task automatic check(input string nm, input logic [31:0] seen, exp);
    comparisons++;
    if (seen !== exp) begin
      failures++;
      $display("BAD %s exp %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic tick(input int k);
    repeat (k) @(posedge clk);
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask
  task automatic pulse(input int i);
    ev[i] <= 1'b1;
    @(posedge clk);
    ev[i] <= 1'b0;
  endtask
  // second valid cycle must be ignored: one load per re-arm
  task automatic load(input logic [SEL_ALL_W-1:0] s);
    apb(1'b1, ADDR_CTRL, 32'h2);
    nvmSel <= s;
    nvmValid <= 1'b1;
    @(posedge clk);
    nvmSel <= 20'h0;
    @(posedge clk);
    nvmValid <= 1'b0;
    tick(2);
    apb(1'b0, ADDR_SEL, 32'h0);
    check("sel", rd, {12'h000, s});
  endtask
  task automatic count(input int p, input int k);
    logic prev;
    n = 0;
    prev = padOut[p];
    repeat (k) begin
      @(posedge clk);
      if (padOut[p] !== prev) n++;
      prev = padOut[p];
    end
  endtask
  task automatic complete_run;
    if (failures == 0 && comparisons > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  initial begin
    #100000;
    failures++;
    complete_run();
  end
  // =====
  // scenarios
  initial begin
    tick(5);
    rst_n <= 1'b1;
    tick(3);
    apb(1'b0, ADDR_SEL, 32'h0);
    check("def", rd, {12'h000, OPT_SLEEP, OPT_SEND_LED, OPT_RECV_LED,
      OPT_LINE_DRV});
    check("line", {padOe[0], padOut[0]}, 2'b11);
    uartSending <= 1'b0;
    usbSuspend <= 1'b1;
    tick(3);
    check("line", padOut[0], 1'b0);
    check("sleep", padOut[3], 1'b0);
    usbSuspend <= 1'b0;
    tick(3);
    check("sleep", padOut[3], 1'b1);
    for (int i = 0; i < 2; i++) begin
      pulse(i);
      tick(3);
      check("led", padOut[2 - i], 1'b0);
      tick(5);
      check("led", padOut[2 - i], 1'b0);
      tick(5);
      check("led", padOut[2 - i], 1'b1);
    end
    load({OPT_TRAFFIC_LED, OPT_DRIVE0, OPT_DRIVE1, OPT_TRISTATE});
    check("cst", {padOe[2:0], padOut[2:1]}, 5'b11001);
    for (int i = 0; i < 2; i++) begin
      pulse(i);
      tick(3);
      check("trf", padOut[3], 1'b0);
      tick(LS + 3);
    end
    usbConfigured <= 1'b0;
    load({OPT_TIMESTAMP, OPT_POWER_EN, OPT_KEEP_AWAKE, OPT_BUS_SENSE});
    check("pwr", padOut[2], 1'b1);
    check("pull", {padOe[1:0], padPullUp[1:0]}, 4'b0011);
    usbConfigured <= 1'b1;
    extDrv <= 4'h3;
    tick(5);
    check("sns", {busPowerSense, keepAwake}, 2'b11);
    check("pwr", padOut[2], 1'b0);
    n = padOut[3];
    pulse(2);
    tick(3);
    check("ts", padOut[3], !n[0]);
    apb(1'b1, ADDR_CTRL, 32'h1);
    extDrv <= 4'h0;
    usbSuspend <= 1'b1;
    tick(4);
    check("susp", {padOut[2], padPullDn[1:0]}, 3'b111);
    usbSuspend <= 1'b0;
    load({OPT_CLK6, OPT_CLK12, OPT_CLK24, OPT_GPIO});
    apb(1'b1, ADDR_GPIO, 32'h11);
    tick(1);
    check("gpo", {padOe[0], padOut[0]}, 2'b11);
    apb(1'b1, ADDR_GPIO, 32'h0);
    extDrv <= 4'h1;
    extLvl <= 4'h0;
    tick(4);
    apb(1'b0, ADDR_STATUS, 32'h0);
    check("gpi", rd[0], 1'b0);
    extDrv <= 4'h0;
    for (int i = 1; i < 4; i++) begin
      e = 96 >> (i - 1);
      count(i, 200);
      check("clk", 32'(n >= e - 2 && n <= e + 2), 32'h1);
    end
    usbSuspend <= 1'b1;
    tick(3);
    count(1, 50);
    check("stop", 32'(n), 32'h0);
    usbSuspend <= 1'b0;
    load({OPT_CHARGER_N, OPT_CHARGER, OPT_RD_STROBE, OPT_WR_STROBE});
    for (int i = 0; i < 2; i++) begin
      chargerDetected <= i[0];
      parallelWriteStrobeN <= i[0];
      parallelReadStrobeN <= !i[0];
      tick(3);
      check("sig", padOut, {2{!i[0], i[0]}});
    end
    apb(1'b0, 8'h10, 32'h0);
    check("map", {err, rd[30:0]}, 32'h80000000);
    apb(1'b1, ADDR_SEL, 32'h0);
    check("ro", err, 1'b1);
    complete_run();
  end
endmodule
